//--- design/freeze_wake_defs.svh
/*
 Constants for the freeze wake logic.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef FREEZE_WAKE_DEFS_SVH
`define FREEZE_WAKE_DEFS_SVH
`define NUM_PINS 8
`define ROLE_W 3
`define ROLE_OFF 3'h0
`define ROLE_CHANGE 3'h1
`define ROLE_ON1 3'h2
`define ROLE_ON0 3'h3
`define ROLE_OUTPUT 3'h4
`define OSC_SLOW_KHZ 1000
`define OSC_FAST_KHZ 50000
`define CLK_SEL_SLOW 1'b0
`define CLK_SEL_FAST 1'b1
`define RAM_SUSPEND 1'b0
`define RAM_SLEEP 1'b1
`endif

//--- design/freeze_wake_pkg.sv
/*
 Types shared by the freeze wake logic.
 Assumes the constants header is on the include path.
*/
`include "freeze_wake_defs.svh"
package freeze_wake_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_FROZEN = 3'b010,
    ST_EXIT = 3'b100
  } freeze_state_t;
endpackage

//--- design/pin_wake_eval.sv
/*
 Combines per-pin wake roles into one pin wake condition.
 Assumes pins already synchronised and reference levels latched.
*/
`timescale 1ns/1ps
`include "freeze_wake_defs.svh"
module pin_wake_eval
  import freeze_wake_pkg::*;
(
  input wire logic [`NUM_PINS-1:0] pin_level,
  input wire logic [`NUM_PINS-1:0] ref_level,
  input wire logic [`NUM_PINS*`ROLE_W-1:0] pin_role,
  input wire logic [`NUM_PINS-1:0] pin_is_input,
  output logic pin_wake
);
  logic any_change;
  logic all_on1;
  logic all_on0;
  logic any_sig;
  logic [`ROLE_W-1:0] role;
  always_comb begin
    any_change = 1'b0;
    all_on1 = 1'b1;
    all_on0 = 1'b1;
    any_sig = 1'b0;
    role = `ROLE_OFF;
    for (int i = 0; i < `NUM_PINS; i++) begin
      role = pin_role[i*`ROLE_W +: `ROLE_W];
      if (pin_is_input[i]) begin
        if (role == `ROLE_CHANGE) begin
          any_change = any_change | (pin_level[i] ^ ref_level[i]);
        end
        if (role == `ROLE_ON1) begin
          any_sig = 1'b1;
          all_on1 = all_on1 & pin_level[i];
        end
        if (role == `ROLE_ON0) begin
          any_sig = 1'b1;
          all_on0 = all_on0 & ~pin_level[i];
        end
      end
    end
    // Empty signature group never wakes
    pin_wake = (any_sig & all_on0 & all_on1) | any_change;
  end
endmodule

//--- design/freeze_wake_top.sv
/*
 Freeze mode exit logic: pin wake, counter wake, interrupt routing,
 standby clock choice, fabric RAM retention and idle pin handling.
 Assumes the counter wake and force bit come from logic on mclk;
 pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "freeze_wake_defs.svh"
// Operation
// - Pin or counter wake ends freeze
// - Only input pins join wake decision
// - Latch activity pin level at entry
// - Level differing from reference requests wake
// - Activity requests combine by OR
// - Signature needs all pins matching together
// - High match expects one, low zero
// - Low group AND high group
// - Pin wake is signature OR activity
// - One signature mismatch blocks signature
// - Idle pins tristate or hold level
// - Force bit raises counter wake interrupt
// - Wake interrupt to controller, fabric, processor
// - Processor and fabric delivery separately enabled
// - Standby clock from slow or fast oscillator
// - Fabric RAMs in suspend or sleep
// - Suspend keeps contents, sleep loses them
module freeze_wake_top
  import freeze_wake_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic freeze_req,
  input wire logic [`NUM_PINS-1:0] pin_in,
  input wire logic [`NUM_PINS-1:0] pin_out_val,
  input wire logic [`NUM_PINS-1:0] pin_drive,
  input wire logic [`NUM_PINS-1:0] pin_is_input,
  input wire logic [`NUM_PINS*`ROLE_W-1:0] pin_role,
  input wire logic [`NUM_PINS-1:0] pin_hold_cfg,
  input wire logic counter_wake,
  input wire logic wake_force,
  input wire logic irq_cpu_en,
  input wire logic irq_fabric_en,
  input wire logic stby_clk_sel,
  input wire logic ram_state_sel,
  output logic [`NUM_PINS-1:0] pin_out,
  output logic [`NUM_PINS-1:0] pin_oe_n,
  output logic in_freeze,
  output logic wake_irq_ctrl,
  output logic wake_irq_cpu,
  output logic wake_irq_fabric,
  output logic stby_clk_fast,
  output logic fabric_large_ram_sleep,
  output logic fabric_micro_ram_sleep,
  output logic ram_contents_valid,
  output logic wake_pulse
);
  freeze_state_t state_r, state_nxt;
  logic [`NUM_PINS-1:0] sync1_r, sync2_r;
  logic [`NUM_PINS-1:0] ref_r, ref_nxt;
  logic [`NUM_PINS-1:0] last_r, last_nxt;
  logic [`NUM_PINS-1:0] pin_out_r, pin_out_nxt;
  logic [`NUM_PINS-1:0] oe_n_r, oe_n_nxt;
  logic irq_r, irq_nxt;
  logic clk_r, clk_nxt;
  logic sleep_r, sleep_nxt;
  logic valid_r, valid_nxt;
  logic wake_r, wake_nxt;
  logic pin_wake;

  function automatic logic joins_wake(input logic [`ROLE_W-1:0] r,
                                      input logic is_in);
    joins_wake = is_in & ((r == `ROLE_CHANGE) | (r == `ROLE_ON1) |
                          (r == `ROLE_ON0));
  endfunction

  // Two-stage synchroniser on pins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  pin_wake_eval pin_wake_eval_i (
    .pin_level(sync2_r),
    .ref_level(ref_r),
    .pin_role(pin_role),
    .pin_is_input(pin_is_input),
    .pin_wake(pin_wake)
  );

  always_comb begin
    state_nxt = state_r;
    ref_nxt = ref_r;
    last_nxt = last_r;
    pin_out_nxt = pin_out_r;
    oe_n_nxt = oe_n_r;
    irq_nxt = counter_wake | wake_force;
    clk_nxt = clk_r;
    sleep_nxt = sleep_r;
    valid_nxt = valid_r;
    wake_nxt = 1'b0;
    case (state_r)
      ST_ACTIVE: begin
        pin_out_nxt = pin_out_val;
        oe_n_nxt = ~pin_drive;
        last_nxt = pin_out_val;
        if (freeze_req) begin
          state_nxt = ST_FROZEN;
          ref_nxt = sync2_r;
          clk_nxt = (stby_clk_sel == `CLK_SEL_FAST);
          sleep_nxt = (ram_state_sel == `RAM_SLEEP);
          for (int i = 0; i < `NUM_PINS; i++) begin
            if (!joins_wake(pin_role[i*`ROLE_W +: `ROLE_W],
                            pin_is_input[i])) begin
              // Hold on a driven pin keeps last level, else tristate
              oe_n_nxt[i] = ~(pin_hold_cfg[i] & pin_drive[i]);
              pin_out_nxt[i] = last_r[i] & pin_hold_cfg[i];
            end else begin
              oe_n_nxt[i] = 1'b1;
              pin_out_nxt[i] = 1'b0;
            end
          end
        end
      end
      ST_FROZEN: begin
        if (pin_wake || irq_r) begin
          state_nxt = ST_EXIT;
          wake_nxt = 1'b1;
          valid_nxt = ~sleep_r;
        end
      end
      ST_EXIT: begin
        state_nxt = ST_ACTIVE;
        sleep_nxt = 1'b0;
        clk_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_ACTIVE;
      ref_r <= '0;
      last_r <= '0;
      pin_out_r <= '0;
      oe_n_r <= '1;
      irq_r <= 1'b0;
      clk_r <= 1'b0;
      sleep_r <= 1'b0;
      valid_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ref_r <= ref_nxt;
      last_r <= last_nxt;
      pin_out_r <= pin_out_nxt;
      oe_n_r <= oe_n_nxt;
      irq_r <= irq_nxt;
      clk_r <= clk_nxt;
      sleep_r <= sleep_nxt;
      valid_r <= valid_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe_n = oe_n_r;
  assign in_freeze = (state_r == ST_FROZEN);
  assign wake_irq_ctrl = irq_r;
  assign wake_irq_cpu = irq_r & irq_cpu_en;
  assign wake_irq_fabric = irq_r & irq_fabric_en;
  assign stby_clk_fast = clk_r;
  assign fabric_large_ram_sleep = sleep_r;
  assign fabric_micro_ram_sleep = sleep_r;
  assign ram_contents_valid = valid_r;
  assign wake_pulse = wake_r;
endmodule

//--- sim/freeze_wake_asserts.sv
/* Checks of freeze exit, irq routing and retention.
 Assumes bind to freeze_wake_top. */
`timescale 1ns/1ps
module freeze_wake_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic freeze_req,
  input wire logic counter_wake,
  input wire logic wake_force,
  input wire logic irq_cpu_en,
  input wire logic irq_fabric_en,
  input wire logic stby_clk_sel,
  input wire logic ram_state_sel,
  input wire logic in_freeze,
  input wire logic wake_irq_ctrl,
  input wire logic wake_irq_cpu,
  input wire logic wake_irq_fabric,
  input wire logic stby_clk_fast,
  input wire logic fabric_large_ram_sleep,
  input wire logic ram_contents_valid,
  input wire logic wake_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_exit;
    !in_freeze && wake_pulse;
  endsequence
  a_irq_raise: assert property ((counter_wake || wake_force) |=>
    wake_irq_ctrl) else $error("irq missing");
  a_irq_quiet: assert property (!(counter_wake || wake_force) |=>
    !wake_irq_ctrl) else $error("irq without cause");
  a_cpu_gate: assert property (
    wake_irq_cpu == (wake_irq_ctrl && irq_cpu_en)) else $error("cpu irq");
  a_fabric_gate: assert property (
    wake_irq_fabric == (wake_irq_ctrl && irq_fabric_en)) else $error("fab irq");
  a_irq_exit: assert property (in_freeze && wake_irq_ctrl |=> s_exit)
    else $error("irq did not end freeze");
  a_pulse_once: assert property (wake_pulse |=> !wake_pulse && !in_freeze)
    else $error("wake pulse too long");
  a_enter_freeze: assert property (
    !in_freeze && !wake_pulse && freeze_req |=> in_freeze)
    else $error("freeze not entered");
  a_clk_source: assert property (
    in_freeze && $past(in_freeze) && $stable(stby_clk_sel) |->
    stby_clk_fast == stby_clk_sel) else $error("standby clock");
  a_ram_state: assert property (
    in_freeze && $past(in_freeze) && $stable(ram_state_sel) |->
    fabric_large_ram_sleep == ram_state_sel) else $error("ram state");
  a_ram_keep: assert property (s_exit ##0 $stable(ram_state_sel) |->
    ram_contents_valid == !ram_state_sel) else $error("ram valid");
endmodule
bind freeze_wake_top freeze_wake_asserts freeze_wake_asserts_i (.mclk,
  .nrst, .freeze_req, .counter_wake, .wake_force, .irq_cpu_en,
  .irq_fabric_en, .stby_clk_sel, .ram_state_sel, .in_freeze, .wake_irq_ctrl,
  .wake_irq_cpu, .wake_irq_fabric, .stby_clk_fast, .fabric_large_ram_sleep,
  .ram_contents_valid, .wake_pulse);

//--- sim/pin_counter_model.sv
/* Model of the wake pins and the counter alarm.
 Assumes the bench sets levels between edges. */
`timescale 1ns/1ps
`include "freeze_wake_defs.svh"
module pin_counter_model (
  input wire logic mclk,
  input wire logic [`NUM_PINS-1:0] lvl,
  input wire logic alarm,
  output logic [`NUM_PINS-1:0] pins,
  output logic alarm_out
);
  always @(posedge mclk) begin
    pins <= lvl;
    alarm_out <= alarm;
  end
endmodule

//--- sim/freeze_wake_top_tb.sv
/* Self-checking bench for the freeze wake logic.
 Assumes the pin model and checker are compiled before it. */
`timescale 1ns/1ps
`include "freeze_wake_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module freeze_wake_top_tb;
  logic mclk = 0, nrst = 0, freeze_req = 0, alarm = 0, wake_force = 0;
  logic irq_cpu_en = 1, irq_fabric_en = 0, stby_clk_sel = 1;
  logic ram_state_sel = 0, counter_wake, in_freeze, wake_irq_ctrl;
  logic wake_irq_cpu, wake_irq_fabric, stby_clk_fast, large_sleep;
  logic micro_sleep, ram_contents_valid, wake_pulse;
  logic [`NUM_PINS-1:0] lvl = 8'h04, pin_in, pin_out, pin_oe_n;
  logic [`NUM_PINS*`ROLE_W-1:0] roles = {`ROLE_OFF, `ROLE_OFF, `ROLE_OFF,
    `ROLE_OFF, `ROLE_CHANGE, `ROLE_ON0, `ROLE_ON1, `ROLE_CHANGE};
  int n_mismatch = 0, total_checks = 0;
  always #10 mclk = ~mclk;
  pin_counter_model pin_counter_model_i (.mclk, .lvl, .alarm,
    .pins(pin_in), .alarm_out(counter_wake));
  freeze_wake_top freeze_wake_top_i (.mclk, .nrst, .freeze_req, .pin_in,
    .pin_out_val(8'h10), .pin_drive(8'h18), .pin_is_input(8'h07),
    .pin_role(roles), .pin_hold_cfg(8'h10),
    .counter_wake, .wake_force, .irq_cpu_en, .irq_fabric_en, .stby_clk_sel,
    .ram_state_sel, .pin_out, .pin_oe_n, .in_freeze, .wake_irq_ctrl,
    .wake_irq_cpu, .wake_irq_fabric, .stby_clk_fast,
    .fabric_large_ram_sleep(large_sleep),
    .fabric_micro_ram_sleep(micro_sleep), .ram_contents_valid, .wake_pulse);
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic enter;
    repeat (3) @(negedge mclk);
    freeze_req = 1;
    @(negedge mclk) freeze_req = 0;
    `CHK("in_freeze", 1'b1, in_freeze)
  endtask
  task automatic wake(input logic exp, input int n);
    for (int i = 0; i < n && wake_pulse !== 1'b1; i++) @(negedge mclk);
    `CHK("wake_pulse", exp, wake_pulse)
    if (exp && wake_pulse !== 1'b1) close_out();
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1;
    enter();
    `CHK("idle oe", 8'hEF, pin_oe_n)
    `CHK("idle hold", 8'h10, pin_out)
    lvl = 8'h0C;
    wake(1'b0, 8);
    `CHK("clk fast", 1'b1, stby_clk_fast)
    `CHK("ram sleep", 1'b0, micro_sleep)
    lvl = 8'h0D;
    wake(1'b1, 10);
    `CHK("ram valid", 1'b1, ram_contents_valid)
    $display("rising activity test done");
    stby_clk_sel = 0;
    ram_state_sel = 1;
    enter();
    `CHK("clk fast", 1'b0, stby_clk_fast)
    `CHK("ram sleep", 1'b1, large_sleep)
    lvl = 8'h0C;
    wake(1'b1, 10);
    `CHK("ram valid", 1'b0, ram_contents_valid)
    $display("falling activity test done");
    enter();
    lvl = 8'h0E;
    wake(1'b0, 8);
    lvl = 8'h0A;
    wake(1'b1, 10);
    $display("signature test done");
    lvl = 8'h0C;
    enter();
    @(negedge mclk) wake_force = 1;
    @(negedge mclk) wake_force = 0;
    `CHK("irq cpu", 1'b1, wake_irq_cpu)
    `CHK("irq fabric", 1'b0, wake_irq_fabric)
    wake(1'b1, 4);
    irq_fabric_en = 1;
    enter();
    @(negedge mclk) alarm = 1;
    @(negedge mclk) alarm = 0;
    @(negedge mclk);
    `CHK("irq fabric", 1'b1, wake_irq_fabric)
    wake(1'b1, 4);
    $display("counter wake test done");
    roles[8:3] = {`ROLE_OFF, `ROLE_OFF};
    enter();
    wake(1'b0, 8);
    lvl = 8'h0D;
    wake(1'b1, 10);
    $display("empty signature test done");
    close_out();
  end
endmodule
